// ===== verilog/urx_regs.v
// serial port register block: axi4-lite slave, receive fifo, timeout and error interrupt sources
// assumes: frame shifter, baud generator and flag logic sit outside on the same clock
//
// Overview of operation
// - timeout raised: fifo non-empty, idle period elapsed
// - missing valid start bit counts as idle
// - timeout cleared by emptying fifo or clear write
// - error interrupt on framing, parity, break, overrun
// - error causes shown raw and masked, write-clear
// - block decoded at base 0x40300000, fixed offsets
// - offset 0x04 reads errors, write clears them
// - data read pops character, write queues transmit
// - bit 8 flags missing stop bit
// - bit 9 flags parity mismatch
// - break sets bit 10, loads zero character
// - full fifo overrun sets bit 11, keeps contents
// - timeout register read/write, resets to 0x1FF
// - flags, control, level select reset values (flags read straight from line_flags_in)
// - write-only clear register at 0x44
// - four flow-control character registers 0x54-0x60
// - timeout counts oversample ticks, 16 or 8
// - any error-clear write clears overrun
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "urx_map.vh"
module urx_regs #(
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW = 4
) (
    input wire aclk,
    input wire aresetn,
    // axi4-lite slave
    input wire [31:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // from the frame shifter
    input wire rx_char_valid,
    input wire [7:0] rx_char_data,
    input wire rx_char_framing,
    input wire rx_char_parity,
    input wire rx_char_break,
    input wire rx_start_seen,
    input wire rx_sample_tick,
    // from flag and other interrupt logic
    input wire [15:0] line_flags_in,
    input wire [12:0] ext_irq_raw,
    // to the transmitter
    output reg tx_char_valid,
    output reg [7:0] tx_char_data,
    // to neighbouring logic
    output reg [12:0] irq_clear_pulse,
    output reg oversample_select,
    output reg rx_fifo_empty,
    output reg [31:0] rx_line_ctrl_r,
    output reg [31:0] tx_line_ctrl_r,
    output reg [31:0] baud_int_divisor_r,
    output reg [31:0] baud_frac_divisor_r,
    output reg [31:0] main_control_r,
    output reg [31:0] fifo_level_select_r,
    output reg [31:0] dma_request_ctrl_r,
    output reg [31:0] soft_flow_ctrl_r,
    output reg [31:0] resume_char_a_r,
    output reg [31:0] resume_char_b_r,
    output reg [31:0] stop_char_a_r,
    output reg [31:0] stop_char_b_r
);
    // software-visible state kept only here
    reg [31:0] timeout_r; // idle period
    reg [31:0] irq_mask_r; // interrupt mask
    reg [`URX_TMO_W-1:0] tmo_cnt_r; // idle tick counter
    reg [`URX_TMO_W-1:0] tmo_cnt_nxt;
    reg rt_raw_r; // receive timeout source
    reg rt_raw_nxt;
    reg [3:0] err_raw_r; // fe, pe, be, oe sources
    reg [3:0] err_raw_nxt;
    reg [3:0] err_stat_r; // receive error status
    reg [3:0] err_stat_nxt;
    reg ovr_flag_r; // overrun shown in the data word
    // write channel holding
    reg aw_held_r; // address taken, waiting for data
    reg w_held_r; // data taken, waiting for address
    reg [31:0] awaddr_r;
    reg [31:0] wdata_r;
    reg [3:0] wstrb_r;
    // fifo wiring
    wire [10:0] fifo_head;
    wire fifo_empty;
    wire fifo_full;
    wire rx_push;
    wire rx_overrun;
    wire [10:0] rx_entry;
    // decode helpers
    wire do_write;
    wire wr_hit;
    wire [`URX_OFF_W-1:0] wr_off;
    wire ar_take;
    wire rd_hit;
    wire [`URX_OFF_W-1:0] rd_off;
    wire rd_pop;
    wire err_clr_wr;
    wire icr_wr;
    wire [31:0] wr_mask;
    wire [12:0] raw_stat;
    reg [31:0] rd_mux;

    // write happens once both halves are held and no response is pending
    assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
    assign wr_hit = ((awaddr_r & `URX_BASE_MASK) == `URX_BASE);
    assign wr_off = awaddr_r[`URX_OFF_W-1:0];
    assign wr_mask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
    // any write to the error offset clears, data value is irrelevant
    assign err_clr_wr = do_write && wr_hit && (wr_off == `URX_OFF_ERR);
    assign icr_wr = do_write && wr_hit && (wr_off == `URX_OFF_ICR);

    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign rd_hit = ((s_axi_araddr & `URX_BASE_MASK) == `URX_BASE);
    assign rd_off = s_axi_araddr[`URX_OFF_W-1:0];
    // a data read pops the head character
    assign rd_pop = ar_take && rd_hit && (rd_off == `URX_OFF_DATA) && !fifo_empty;

    // break stores a zero character with its flag
    assign rx_entry = {rx_char_break, rx_char_parity, rx_char_framing,
                       rx_char_break ? 8'h00 : rx_char_data};
    // full fifo: shifter content is dropped, stored characters stay
    assign rx_push = rx_char_valid && !fifo_full;
    assign rx_overrun = rx_char_valid && fifo_full;

    assign raw_stat = (ext_irq_raw & ~`URX_IRQ_OWN) |
                      ({{(`URX_IRQ_W-1){1'b0}}, rt_raw_r} << `URX_IRQ_RT) |
                      ({{(`URX_IRQ_W-4){1'b0}}, err_raw_r} << `URX_IRQ_FE);

    // receive fifo; fifo off in line control means one holding slot
    urx_rx_fifo #(
        .WIDTH(11),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_rx_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .single_mode(!rx_line_ctrl_r[`URX_RXLC_FEN]),
        .push(rx_push),
        .push_data(rx_entry),
        .pop(rd_pop),
        .head(fifo_head),
        .empty(fifo_empty),
        .full(fifo_full)
    );

    // read data selection; unlisted and write-only offsets read zero
    always @* begin
        rd_mux = `URX_RST_ZERO;
        case (rd_off)
            `URX_OFF_DATA: begin
                // upper bits stay zero; framing, parity and break flags belong to the popped entry, overrun comes from ovr_flag_r
                rd_mux[7:0] = fifo_head[7:0];
                rd_mux[`URX_DW_FE] = fifo_head[8];
                rd_mux[`URX_DW_PE] = fifo_head[9];
                rd_mux[`URX_DW_BE] = fifo_head[10];
                rd_mux[`URX_DW_OE] = ovr_flag_r;
            end
            `URX_OFF_ERR: rd_mux[3:0] = err_stat_r;
            `URX_OFF_TMO: rd_mux = timeout_r;
            `URX_OFF_FLAGS: rd_mux[15:0] = line_flags_in;
            `URX_OFF_RXLC: rd_mux = rx_line_ctrl_r;
            `URX_OFF_BAUD_INT_DIVISOR: rd_mux = baud_int_divisor_r;
            `URX_OFF_BAUD_FRAC_DIVISOR: rd_mux = baud_frac_divisor_r;
            `URX_OFF_TXLC: rd_mux = tx_line_ctrl_r;
            `URX_OFF_CTRL: rd_mux = main_control_r;
            `URX_OFF_LVL: rd_mux = fifo_level_select_r;
            `URX_OFF_MASK: rd_mux = irq_mask_r;
            `URX_OFF_RAW: rd_mux[12:0] = raw_stat;
            `URX_OFF_MIS: rd_mux[12:0] = raw_stat & irq_mask_r[12:0];
            `URX_OFF_DMA: rd_mux = dma_request_ctrl_r;
            `URX_OFF_SFC: rd_mux = soft_flow_ctrl_r;
            `URX_OFF_RESUME_CHAR_A: rd_mux = resume_char_a_r;
            `URX_OFF_RESUME_CHAR_B: rd_mux = resume_char_b_r;
            `URX_OFF_STOP_CHAR_A: rd_mux = stop_char_a_r;
            `URX_OFF_STOP_CHAR_B: rd_mux = stop_char_b_r;
            default: rd_mux = `URX_RST_ZERO;
        endcase
        if (!rd_hit) begin
            rd_mux = `URX_RST_ZERO;
        end
    end

    // idle counter, held at zero while the fifo is empty; a valid start bit or a stored character restarts it
    always @* begin
        tmo_cnt_nxt = tmo_cnt_r;
        rt_raw_nxt = rt_raw_r;
        if (fifo_empty || rx_push || rx_start_seen) begin
            tmo_cnt_nxt = {`URX_TMO_W{1'b0}};
        end else if (rx_sample_tick && !rt_raw_r) begin
            // one tick per oversample period: period / (factor * baud)
            tmo_cnt_nxt = tmo_cnt_r + 1'b1;
        end
        // clear first so that a same-cycle set wins
        if (fifo_empty) begin
            rt_raw_nxt = 1'b0;
        end
        if (icr_wr && wdata_r[`URX_IRQ_RT] && wstrb_r[0]) begin
            rt_raw_nxt = 1'b0;
        end
        if (!fifo_empty && !rx_push && !rx_start_seen && rx_sample_tick &&
            (tmo_cnt_r + 1'b1 >= timeout_r[`URX_TMO_W-1:0])) begin
            rt_raw_nxt = 1'b1;
        end
    end

    // error interrupt sources and error status, set beats clear
    always @* begin
        err_raw_nxt = err_raw_r;
        err_stat_nxt = err_stat_r;
        if (icr_wr) begin
            err_raw_nxt = err_raw_r & ~(wdata_r[`URX_IRQ_OE:`URX_IRQ_FE] & wr_mask[`URX_IRQ_OE:`URX_IRQ_FE]);
        end
        if (err_clr_wr) begin
            err_stat_nxt = 4'h0;
        end
        if (rx_push) begin
            err_raw_nxt = err_raw_nxt | {1'b0, rx_char_break, rx_char_parity, rx_char_framing};
        end
        if (rx_overrun) begin
            err_raw_nxt[3] = 1'b1;
            err_stat_nxt[`URX_ES_OE] = 1'b1;
        end
        if (rd_pop) begin
            // status follows the character just read
            err_stat_nxt[2:0] = err_stat_nxt[2:0] | fifo_head[10:8];
        end
    end

    // interrupt and receive state registers
    always @(posedge aclk) begin
        if (!aresetn) begin
            tmo_cnt_r <= {`URX_TMO_W{1'b0}};
            rt_raw_r <= 1'b0;
            err_raw_r <= 4'h0;
            err_stat_r <= 4'h0;
            ovr_flag_r <= 1'b0;
            rx_fifo_empty <= 1'b1;
            oversample_select <= 1'b0;
        end else begin
            tmo_cnt_r <= tmo_cnt_nxt;
            rt_raw_r <= rt_raw_nxt;
            err_raw_r <= err_raw_nxt;
            err_stat_r <= err_stat_nxt;
            rx_fifo_empty <= fifo_empty;
            oversample_select <= main_control_r[`URX_CTRL_OVS];
            // flag drops once a character could be stored again
            if (rx_overrun) begin
                ovr_flag_r <= 1'b1;
            end else if (!fifo_full) begin
                ovr_flag_r <= 1'b0;
            end
        end
    end

    // write address and data channels, taken in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= `URX_RST_ZERO;
            wdata_r <= `URX_RST_ZERO;
            wstrb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `URX_RESP_OK;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_r <= s_axi_awaddr;
                aw_held_r <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
                w_held_r <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `URX_RESP_OK : `URX_RESP_DEC;
            end
            // ready returns only after the response is taken
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // read channel: one read at a time, answer one cycle after the address
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= `URX_RST_ZERO;
            s_axi_rresp <= `URX_RESP_OK;
        end else begin
            if (ar_take) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_hit ? `URX_RESP_OK : `URX_RESP_DEC;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // software registers, byte strobes respected
    always @(posedge aclk) begin
        if (!aresetn) begin
            timeout_r <= `URX_RST_TMO;
            main_control_r <= `URX_RST_CTRL;
            fifo_level_select_r <= `URX_RST_LVL;
            irq_mask_r <= `URX_RST_ZERO;
            rx_line_ctrl_r <= `URX_RST_ZERO;
            tx_line_ctrl_r <= `URX_RST_ZERO;
            baud_int_divisor_r <= `URX_RST_ZERO;
            baud_frac_divisor_r <= `URX_RST_ZERO;
            dma_request_ctrl_r <= `URX_RST_ZERO;
            soft_flow_ctrl_r <= `URX_RST_ZERO;
            resume_char_a_r <= `URX_RST_ZERO;
            resume_char_b_r <= `URX_RST_ZERO;
            stop_char_a_r <= `URX_RST_ZERO;
            stop_char_b_r <= `URX_RST_ZERO;
            tx_char_valid <= 1'b0;
            tx_char_data <= 8'h00;
            irq_clear_pulse <= 13'h0000;
        end else begin
            tx_char_valid <= 1'b0;
            irq_clear_pulse <= 13'h0000;
            if (do_write && wr_hit) begin
                case (wr_off)
                    `URX_OFF_DATA: begin
                        // only the low byte queues a character
                        if (wstrb_r[0]) begin
                            tx_char_valid <= 1'b1;
                            tx_char_data <= wdata_r[7:0];
                        end
                    end
                    `URX_OFF_TMO: begin
                        // period field only, upper bits reserved
                        timeout_r[`URX_TMO_W-1:0] <= (timeout_r[`URX_TMO_W-1:0] & ~wr_mask[`URX_TMO_W-1:0]) |
                                                     (wdata_r[`URX_TMO_W-1:0] & wr_mask[`URX_TMO_W-1:0]);
                    end
                    `URX_OFF_RXLC: rx_line_ctrl_r <= (rx_line_ctrl_r & ~wr_mask) | (wdata_r & wr_mask);
                    `URX_OFF_BAUD_INT_DIVISOR: baud_int_divisor_r <= (baud_int_divisor_r & ~wr_mask) | (wdata_r & wr_mask);
                    `URX_OFF_BAUD_FRAC_DIVISOR: baud_frac_divisor_r <= (baud_frac_divisor_r & ~wr_mask) | (wdata_r & wr_mask);
                    `URX_OFF_TXLC: tx_line_ctrl_r <= (tx_line_ctrl_r & ~wr_mask) | (wdata_r & wr_mask);
                    `URX_OFF_CTRL: main_control_r <= (main_control_r & ~wr_mask) | (wdata_r & wr_mask);
                    `URX_OFF_LVL: fifo_level_select_r <= (fifo_level_select_r & ~wr_mask) | (wdata_r & wr_mask);
                    `URX_OFF_MASK: irq_mask_r <= (irq_mask_r & ~wr_mask) | (wdata_r & wr_mask);
                    `URX_OFF_ICR: begin
                        // sources kept elsewhere get a one-cycle clear
                        irq_clear_pulse <= wdata_r[12:0] & wr_mask[12:0] & ~`URX_IRQ_OWN;
                    end
                    `URX_OFF_DMA: dma_request_ctrl_r <= (dma_request_ctrl_r & ~wr_mask) | (wdata_r & wr_mask);
                    `URX_OFF_SFC: soft_flow_ctrl_r <= (soft_flow_ctrl_r & ~wr_mask) | (wdata_r & wr_mask);
                    `URX_OFF_RESUME_CHAR_A: resume_char_a_r <= (resume_char_a_r & ~wr_mask) | (wdata_r & wr_mask);
                    `URX_OFF_RESUME_CHAR_B: resume_char_b_r <= (resume_char_b_r & ~wr_mask) | (wdata_r & wr_mask);
                    `URX_OFF_STOP_CHAR_A: stop_char_a_r <= (stop_char_a_r & ~wr_mask) | (wdata_r & wr_mask);
                    `URX_OFF_STOP_CHAR_B: stop_char_b_r <= (stop_char_b_r & ~wr_mask) | (wdata_r & wr_mask);
                    default: begin
                        // read-only, error-clear and unlisted offsets store nothing
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ===== verilog/urx_map.vh
// register map and field layout of the serial port register block
// assumes: included by the design files, byte addresses on a 32-bit bus
`ifndef URX_MAP_VH
`define URX_MAP_VH

// base decode: block occupies one 128-byte window
`define URX_BASE 32'h40300000
`define URX_BASE_MASK 32'hFFFFFF80
`define URX_OFF_W 7

// byte offsets inside the window
`define URX_OFF_DATA 7'h00
`define URX_OFF_ERR 7'h04
`define URX_OFF_TMO 7'h0C
`define URX_OFF_FLAGS 7'h18
`define URX_OFF_RXLC 7'h1C
`define URX_OFF_BAUD_INT_DIVISOR 7'h24
`define URX_OFF_BAUD_FRAC_DIVISOR 7'h28
`define URX_OFF_TXLC 7'h2C
`define URX_OFF_CTRL 7'h30
`define URX_OFF_LVL 7'h34
`define URX_OFF_MASK 7'h38
`define URX_OFF_RAW 7'h3C
`define URX_OFF_MIS 7'h40
`define URX_OFF_ICR 7'h44
`define URX_OFF_DMA 7'h48
`define URX_OFF_SFC 7'h50
`define URX_OFF_RESUME_CHAR_A 7'h54
`define URX_OFF_RESUME_CHAR_B 7'h58
`define URX_OFF_STOP_CHAR_A 7'h5C
`define URX_OFF_STOP_CHAR_B 7'h60

// reset values
`define URX_RST_ZERO 32'h00000000
`define URX_RST_TMO 32'h000001FF
`define URX_RST_FLAGS 32'h00001E90
`define URX_RST_CTRL 32'h00040300
`define URX_RST_LVL 32'h00000012

// timeout period field width
`define URX_TMO_W 22

// data word fields
`define URX_DW_FE 8
`define URX_DW_PE 9
`define URX_DW_BE 10
`define URX_DW_OE 11

// error status fields
`define URX_ES_FE 0
`define URX_ES_PE 1
`define URX_ES_BE 2
`define URX_ES_OE 3

// raw interrupt status fields (13 bits wide)
`define URX_IRQ_W 13
`define URX_IRQ_RT 6
`define URX_IRQ_FE 7
`define URX_IRQ_PE 8
`define URX_IRQ_BE 9
`define URX_IRQ_OE 10
// bits owned here; the others come from neighbouring logic
`define URX_IRQ_OWN 13'h07C0

// fifo enable in the receive line control register
`define URX_RXLC_FEN 4
// oversample select in the main control register
`define URX_CTRL_OVS 19

// axi responses
`define URX_RESP_OK 2'h0
`define URX_RESP_DEC 2'h3

`endif

// ===== verilog/urx_rx_fifo.v
// receive fifo holding one character plus its error flags per entry
// assumes: push and pop from logic on the same clock, never push when full
`timescale 1ns/100ps
`default_nettype none
module urx_rx_fifo #(
    parameter WIDTH = 11,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire aclk,
    input wire aresetn,
    input wire single_mode,
    input wire push,
    input wire [WIDTH-1:0] push_data,
    input wire pop,
    output wire [WIDTH-1:0] head,
    output wire empty,
    output wire full
);
    reg [WIDTH-1:0] mem [0:DEPTH-1]; // character storage
    reg [AW-1:0] wr_ptr_r; // next free slot
    reg [AW-1:0] rd_ptr_r; // head slot
    reg [AW:0] count_r; // entries held
    wire do_pop; // pop only what exists
    wire do_push; // push only into space

    assign empty = (count_r == {(AW+1){1'b0}});
    // fifo off means one holding location only
    assign full = single_mode ? !empty : (count_r == DEPTH[AW:0]);
    assign head = mem[rd_ptr_r];
    assign do_pop = pop && !empty;
    assign do_push = push && (!full || do_pop);

    // storage write, no reset needed on data
    always @(posedge aclk) begin
        if (do_push) begin
            mem[wr_ptr_r] <= push_data;
        end
    end

    // pointers and occupancy
    always @(posedge aclk) begin
        if (!aresetn) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
        end else begin
            if (do_push) begin
                wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
            end
            if (do_push && !do_pop) begin
                count_r <= count_r + 1'b1;
            end else if (do_pop && !do_push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== verification/urx_regs_asserts.sv
// checker: bus handshakes, decode errors and transmit queueing of the register block
// assumes: bound to urx_regs, one clock domain
`timescale 1ns/100ps
`default_nettype none
module urx_regs_asserts (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic tx_char_valid,
    input wire logic [7:0] tx_char_data
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // both write channels taken at one edge
    sequence wtake;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    wr_resp_a: assert property (wtake |=> !s_axi_awready ##1 s_axi_bvalid) else $error("write not answered");
    dec_err_a: assert property (wtake ##0 s_axi_awaddr[31:7] != 25'h806000 |=> ##1 s_axi_bresp == 2'h3)
        else $error("outside write not refused");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
    b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready) else $error("b stuck");
    rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready) else $error("no read");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("r dropped");
    tx_queue_a: assert property (wtake ##0 s_axi_awaddr == 32'h40300000 && s_axi_wstrb[0]
        |=> ##1 tx_char_valid && tx_char_data == $past(s_axi_wdata[7:0], 2)) else $error("char not queued");
    tx_pulse_a: assert property (tx_char_valid |=> !tx_char_valid) else $error("queue pulse too long");
endmodule
bind urx_regs urx_regs_asserts u_chk (.*);
`default_nettype wire

// ===== verification/urx_far_end.sv
// far end model: frame shifter handing over received characters, oversample ticks
// assumes: same clock as the register block; a tick every fourth cycle
`timescale 1ns/100ps
`default_nettype none
module urx_far_end (
    input wire logic aclk,
    output logic rx_char_valid,
    output logic [7:0] rx_char_data,
    output logic rx_char_framing,
    output logic rx_char_parity,
    output logic rx_char_break,
    output logic rx_start_seen,
    output logic rx_sample_tick
);
    logic [1:0] cnt = 2'h0; // tick divider
    initial {rx_char_valid, rx_char_data, rx_char_framing, rx_char_parity, rx_char_break, rx_start_seen} = 13'h0;
    initial rx_sample_tick = 1'b0;
    // free-running tick, short so timeouts stay brief
    always @(posedge aclk) begin
        cnt <= cnt + 2'h1;
        rx_sample_tick <= (cnt == 2'h3);
    end
    // one frame: start bit seen, then the character with its flags
    task send(input [7:0] d, input fe, input pe, input br);
        @(posedge aclk);
        rx_start_seen <= 1'b1;
        @(posedge aclk);
        rx_start_seen <= 1'b0;
        rx_char_valid <= 1'b1;
        rx_char_data <= d;
        {rx_char_framing, rx_char_parity, rx_char_break} <= {fe, pe, br};
        @(posedge aclk);
        rx_char_valid <= 1'b0;
        // stale values inverted so nobody relies on them
        rx_char_data <= ~d;
        {rx_char_framing, rx_char_parity, rx_char_break} <= ~{fe, pe, br};
    endtask
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
// testbench: register map, receive errors, timeout and overrun seen over the bus
// assumes: urx_regs with a 4-deep fifo, far end model on the receive side
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic aclk = 0;
    logic aresetn = 0;
    logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, q;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tx_char_valid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [7:0] rx_char_data, tx_char_data;
    logic rx_char_valid, rx_char_framing, rx_char_parity, rx_char_break, rx_start_seen, rx_sample_tick;
    int bad_count = 0, comparisons = 0, i;
    always #5 aclk = ~aclk;
    urx_far_end u_far (.*);
    urx_regs #(.FIFO_DEPTH(4), .FIFO_AW(2)) dut (.*, .s_axi_wstrb(4'hF), .line_flags_in(16'h1E90),
        .ext_irq_raw(13'h0), .irq_clear_pulse(), .oversample_select(), .rx_fifo_empty(), .rx_line_ctrl_r(),
        .tx_line_ctrl_r(), .baud_int_divisor_r(), .baud_frac_divisor_r(), .main_control_r(),
        .fifo_level_select_r(), .dma_request_ctrl_r(), .soft_flow_ctrl_r(), .resume_char_a_r(),
        .resume_char_b_r(), .stop_char_a_r(), .stop_char_b_r());
    task final_report;
        $display("mismatches %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // one bus access; q gets read data or the write response
    task xfer(input w, input [7:0] o, input [31:0] d);
        int n;
        bit fin;
        fin = 0;
        // one idle edge keeps the previous handshake release apart from this request
        @(posedge aclk);
        if (w) begin
            {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {32'h40300000 + o, d, 3'h7};
        end else begin
            {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {32'h40300000 + o, 2'h3};
        end
        for (n = 0; n < 50 && !fin; n++) begin
            @(posedge aclk);
            if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 0;
            if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 0;
            if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 0;
            if (s_axi_bvalid && s_axi_bready) begin
                fin = 1;
                q = {30'h0, s_axi_bresp};
                s_axi_bready <= 0;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                fin = 1;
                q = s_axi_rdata;
                s_axi_rready <= 0;
            end
        end
        if (!fin) begin
            $display("MISMATCH t=%0t bus timeout", $time);
            bad_count++;
            final_report;
        end
    endtask
    // access and compare the answer
    task ck(input w, input [7:0] o, input [31:0] d, input [31:0] e);
        xfer(w, o, d);
        comparisons++;
        if (q !== e) begin
            bad_count++;
            $display("MISMATCH t=%0t off %h got %h exp %h", $time, o, q, e);
        end
    endtask
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        ck(0, 8'h0C, 0, 32'h1FF);
        ck(0, 8'h30, 0, 32'h40300);
        ck(0, 8'h34, 0, 32'h12);
        ck(1, 8'h18, 0, 0);
        ck(0, 8'h18, 0, 32'h1E90);
        ck(0, 8'h44, 0, 0);
        ck(1, 8'h80, 1, 32'h3);
        for (i = 0; i < 4; i++) begin
            ck(1, 8'(8'h54 + 4 * i), 32'hA5 + i, 0);
            ck(0, 8'(8'h54 + 4 * i), 0, 32'hA5 + i);
        end
        $display("register map test done");
        ck(1, 8'h1C, 32'h10, 0);
        ck(1, 8'h38, 32'h300, 0);
        ck(1, 8'h00, 32'h1C3, 0);
        u_far.send(8'h5A, 1, 0, 0);
        u_far.send(8'h33, 0, 1, 0);
        u_far.send(8'hFF, 0, 0, 1);
        ck(0, 8'h3C, 0, 32'h380);
        ck(0, 8'h40, 0, 32'h300);
        ck(0, 8'h00, 0, 32'h15A);
        ck(0, 8'h00, 0, 32'h233);
        ck(0, 8'h00, 0, 32'h400);
        ck(0, 8'h04, 0, 32'h7);
        ck(1, 8'h04, 0, 0);
        ck(0, 8'h04, 0, 0);
        ck(1, 8'h44, 32'h780, 0);
        ck(0, 8'h3C, 0, 0);
        $display("receive error test done");
        ck(1, 8'h0C, 32'h4, 0);
        u_far.send(8'h11, 0, 0, 0);
        ck(0, 8'h3C, 0, 0);
        repeat (40) @(posedge aclk);
        ck(0, 8'h3C, 0, 32'h40);
        ck(1, 8'h0C, 32'h3FFFFF, 0);
        ck(0, 8'h0C, 0, 32'h3FFFFF);
        ck(0, 8'h00, 0, 32'h11);
        ck(0, 8'h3C, 0, 0);
        $display("timeout test done");
        for (i = 0; i < 5; i++) u_far.send(8'(8'h61 + i), 0, 0, 0);
        ck(0, 8'h04, 0, 32'h8);
        ck(0, 8'h3C, 0, 32'h400);
        ck(0, 8'h00, 0, 32'h861);
        for (i = 1; i < 4; i++) ck(0, 8'h00, 0, 32'h61 + i);
        ck(1, 8'h04, 32'hFFFF, 0);
        ck(0, 8'h04, 0, 0);
        $display("overrun test done");
        final_report;
    end
endmodule
`default_nettype wire
